// ---- tb/smbus_bus_peer.sv ----
`timescale 1ns/100ps
// another master on the bus; lines have pull-ups, so released means high
module smbus_bus_peer (
	// serial lines
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic start_cond();
		sda_o = 1'b0;
		#100 scl_o = 1'b0;
		#100;
	endtask
	task automatic stop_cond();
		sda_o = 1'b0;
		#100 scl_o = 1'b1;
		#100 sda_o = 1'b1;
		#100;
	endtask
	// a data one: both high again without a stop
	task automatic release_both();
		sda_o = 1'b1;
		#100 scl_o = 1'b1;
		#100;
	endtask
endmodule

// ---- tb/smbus_config_control_tb.sv ----
`timescale 1ns/100ps
module smbus_config_control_tb;
	logic        clk_i, rst_i, we, scl, sda, en, slv, tick, rld, st, sp, irq;
	logic        s_st, s_sp, s_irq;
	logic [7:0]  addr, wd, rd;
	logic [5:0]  ev;
	logic [3:0]  su, ho;
	int          n_mismatch = 0, n_tests = 0, i;
	// write data, read data, setup and hold
	logic [23:0] rows [4] = '{24'h80_80_13, 24'hB1_91_BC, 24'h82_82_13, 24'hFF_DF_BC};

	smbus_config_control uut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
		.sfr_wdata_i(wd), .sfr_we_i(we), .sfr_rdata_o(rd), .scl_i(scl), .sda_i(sda),
		.t0_ovf_i(ev[0]), .t1_ovf_i(ev[1]), .t2h_ovf_i(ev[2]), .t2l_ovf_i(ev[3]),
		.master_event_i(ev[4]), .slave_event_i(ev[5]), .interface_enable_o(en),
		.slave_active_o(slv), .bit_tick_o(tick), .timeout_reload_o(rld),
		.start_seen_o(st), .stop_event_o(sp), .irq_req_o(irq),
		.setup_clks_o(su), .hold_clks_o(ho));
	smbus_bus_peer peer (.scl_o(scl), .sda_o(sda));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// pulses last one cycle, so keep a sticky copy
	always @(posedge clk_i) begin
		if (st) s_st <= 1'b1;
		if (sp) s_sp <= 1'b1;
		if (irq) s_irq <= 1'b1;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i) {addr, wd, we} = {a, d, 1'b1};
		@(negedge clk_i) we = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_i) addr = a;
		#1 chk(rd, e);
	endtask
	task automatic pulse(input logic [5:0] v, input int n);
		repeat (n) begin
			@(negedge clk_i) ev = v;
			@(negedge clk_i) ev = 6'h00;
		end
		repeat (3) @(negedge clk_i);
	endtask
	task automatic clr();
		{s_st, s_sp, s_irq} = 3'h0;
	endtask
	task automatic end_sim();
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#1000000 n_mismatch++;
		end_sim();
	end
	initial begin
		{rst_i, we, addr, wd, ev} = {1'b1, 1'b0, 8'h00, 8'h00, 6'h00};
		clr();
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		rdc(8'hC1, 8'h00);
		chk(rld, 1'b1);
		for (i = 0; i < 4; i++) begin
			wr(8'hC1, rows[i][23:16]);
			rdc(8'hC1, rows[i][15:8]);
			chk({su, ho}, rows[i][7:0]);
			@(negedge clk_i) ev = 6'h01 << rows[i][17:16];
			#1 chk(tick, 1'b1);
			ev = ~ev & 6'h0F;
			#1 chk(tick, 1'b0);
			ev = 6'h00;
		end
		$display("table done");
		wr(8'hC1, 8'h8C);
		clr();
		peer.start_cond();
		rdc(8'hC1, 8'hAC);
		chk(s_st, 1'b1);
		chk(rld, 1'b0);
		peer.release_both();
		pulse(6'h01, 10);
		chk(rld, 1'b1);
		rdc(8'hC1, 8'hAC);
		pulse(6'h01, 1);
		rdc(8'hC1, 8'h8C);
		chk({s_sp, s_irq}, 2'h3);
		clr();
		peer.start_cond();
		peer.stop_cond();
		repeat (4) @(negedge clk_i);
		rdc(8'hC1, 8'h8C);
		chk(s_sp, 1'b1);
		$display("bus tests done");
		wr(8'hC1, 8'hC0);
		clr();
		pulse(6'h20, 1);
		chk({slv, s_irq}, 2'h0);
		pulse(6'h10, 1);
		chk(s_irq, 1'b1);
		wr(8'hC1, 8'h80);
		clr();
		pulse(6'h20, 1);
		chk({slv, s_irq}, 2'h3);
		wr(8'hC1, 8'h00);
		clr();
		peer.start_cond();
		peer.stop_cond();
		repeat (4) @(negedge clk_i);
		chk({en, s_st, s_sp}, 3'h0);
		wr(8'hC0, 8'hFF);
		rdc(8'hC0, 8'h00);
		rdc(8'hC1, 8'h00);
		$display("mode tests done");
		wr(8'hC1, 8'h8C);
		peer.start_cond();
		rdc(8'hC1, 8'hAC);
		@(negedge clk_i) rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		rdc(8'hC1, 8'h00);
		chk({en, rld, sp, irq}, 4'h4);
		peer.stop_cond();
		repeat (4) @(negedge clk_i);
		chk({en, sp, irq}, 3'h0);
		$display("reset test done");
		end_sim();
	end
endmodule

// ---- verilog/line_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser with edge outputs taken from the second stage onward
module line_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// line
	input  wire logic line_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			last_ff <= 1'b1;
		end else begin
			meta_ff <= line_i;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign rise_o  = sync_ff & ~last_ff;
	assign fall_o  = ~sync_ff & last_ff;
endmodule

// ---- verilog/smbus_cfg_consts.svh ----
`ifndef SMBUS_CFG_CONSTS_SVH
`define SMBUS_CFG_CONSTS_SVH

`define CFG_ADDR          8'hC1
`define CFG_RESET         8'h00
`define BIT_ENABLE        7
`define BIT_INHIBIT       6
`define BIT_BUSY          5
`define BIT_EXTEND        4
`define BIT_SCL_TOE       3
`define BIT_FREE_TOE      2
`define CS_HI             1
`define CS_LO             0
`define FREE_PERIODS      4'hA
`define SETUP_EXT_CLKS    4'hB
`define SETUP_STD_CLKS    4'h1
`define HOLD_EXT_CLKS     4'hC
`define HOLD_STD_CLKS     4'h3
`define SCL_TIMEOUT_MS    25

`endif

// ---- verilog/smbus_cfg_pkg.sv ----
package smbus_cfg_pkg;
	typedef enum logic [1:0] {
		SRC_TIMER0    = 2'h0,
		SRC_TIMER1    = 2'h1,
		SRC_TIMER2_HI = 2'h2,
		SRC_TIMER2_LO = 2'h3
	} clk_src_t;
endpackage

// ---- verilog/smbus_config_control.sv ----
`timescale 1ns/100ps
`include "smbus_cfg_consts.svh"

// Functional notes
// - inhibit set: no slave interrupts, slave withdrawn
// - inhibit clear: slave events reported normally
// - busy bit read-only, writes ignored
// - busy set while transfer in progress
// - busy cleared on stop or free timeout
// - extend: setup 11, hold 12; else hold 3
// - scl timeout: reload timer high, count low
// - both high over 10 periods: act as stop
// - two-bit field selects overflow source
module smbus_config_control (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// special function register port
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_we_i,
	output logic      [7:0] sfr_rdata_o,
	// serial lines
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// timer overflow pulses
	input  wire logic       t0_ovf_i,
	input  wire logic       t1_ovf_i,
	input  wire logic       t2h_ovf_i,
	input  wire logic       t2l_ovf_i,
	// from the transfer engine
	input  wire logic       slave_event_i,
	input  wire logic       master_event_i,
	// control outputs
	output logic            interface_enable_o,
	output logic            slave_active_o,
	output logic            bit_tick_o,
	output logic            timeout_reload_o,
	output logic            start_seen_o,
	output logic            stop_event_o,
	output logic            irq_req_o,
	output logic      [3:0] setup_clks_o,
	output logic      [3:0] hold_clks_o
);
	logic [7:0] cfg_ff;
	logic       busy_ff;
	logic       inh_ff;
	logic [3:0] free_cnt_ff;
	logic       stop_ff;
	logic       irq_ff;
	logic       start_ff;
	logic       scl_s;
	logic       sda_s, sda_r, sda_f;
	logic       en;
	logic       start_det;
	logic       stop_det;
	logic       free_hit;
	logic       tick;

	function automatic logic pick_src(input logic [1:0] sel, input logic [3:0] ovf);
		unique case (smbus_cfg_pkg::clk_src_t'(sel))
			smbus_cfg_pkg::SRC_TIMER0:    pick_src = ovf[0];
			smbus_cfg_pkg::SRC_TIMER1:    pick_src = ovf[1];
			smbus_cfg_pkg::SRC_TIMER2_HI: pick_src = ovf[2];
			smbus_cfg_pkg::SRC_TIMER2_LO: pick_src = ovf[3];
		endcase
	endfunction

	line_sync u_scl (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.line_i  (scl_i),
		.level_o (scl_s),
		.rise_o  (),
		.fall_o  ()
	);
	line_sync u_sda (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.line_i  (sda_i),
		.level_o (sda_s),
		.rise_o  (sda_r),
		.fall_o  (sda_f)
	);

	assign en        = cfg_ff[`BIT_ENABLE];
	// lines are looked at only while enabled
	assign start_det = en & scl_s & sda_f;
	assign stop_det  = en & scl_s & sda_r;
	assign tick      = pick_src(cfg_ff[`CS_HI:`CS_LO],
		{t2l_ovf_i, t2h_ovf_i, t1_ovf_i, t0_ovf_i});

	// configuration register; busy bit is not writable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_ff <= `CFG_RESET;
		end else if (sfr_we_i && sfr_addr_i == `CFG_ADDR) begin
			cfg_ff <= sfr_wdata_i & ~(8'h01 << `BIT_BUSY);
		end
	end

	// inhibit takes hold while the bus is idle or at the next start so the current transfer finishes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			inh_ff <= 1'b0;
		end else if (start_det || !busy_ff) begin
			inh_ff <= cfg_ff[`BIT_INHIBIT];
		end
	end

	// bus-free counter, counts selected ticks while both lines high
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			free_cnt_ff <= 4'h0;
		end else if (!en || !cfg_ff[`BIT_FREE_TOE] || !busy_ff || !scl_s || !sda_s) begin
			free_cnt_ff <= 4'h0;
		end else if (tick && free_cnt_ff <= `FREE_PERIODS) begin
			free_cnt_ff <= free_cnt_ff + 4'h1;
		end
	end
	// gated by enable: a write that disables mid-count must not fake a stop
	assign free_hit = en && busy_ff && tick && free_cnt_ff == `FREE_PERIODS;

	// busy: start wins over a simultaneous stop-free edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
		end else if (!en) begin
			busy_ff <= 1'b0;
		end else if (start_det) begin
			busy_ff <= 1'b1;
		end else if (stop_det || free_hit) begin
			busy_ff <= 1'b0;
		end
	end

	// event pulses
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stop_ff  <= 1'b0;
			start_ff <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			stop_ff  <= stop_det | free_hit;
			start_ff <= start_det;
			irq_ff   <= en & ((slave_event_i & ~inh_ff) | master_event_i
				| stop_det | free_hit);
		end
	end

	always_comb begin
		sfr_rdata_o = 8'h00;
		if (sfr_addr_i == `CFG_ADDR) begin
			sfr_rdata_o = cfg_ff;
			sfr_rdata_o[`BIT_BUSY] = busy_ff;
		end
	end

	assign interface_enable_o = en;
	assign slave_active_o     = en & ~inh_ff;
	assign bit_tick_o         = en & tick;
	// reload while scl high or scl timeout off; timer free to count while scl low only with enable and scl timeout set
	assign timeout_reload_o   = ~(en & cfg_ff[`BIT_SCL_TOE]) | scl_s;
	assign start_seen_o       = start_ff;
	assign stop_event_o       = stop_ff;
	assign irq_req_o          = irq_ff;
	assign setup_clks_o = cfg_ff[`BIT_EXTEND] ? `SETUP_EXT_CLKS : `SETUP_STD_CLKS;
	assign hold_clks_o  = cfg_ff[`BIT_EXTEND] ? `HOLD_EXT_CLKS : `HOLD_STD_CLKS;

	a_busy_ro: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_we_i && sfr_addr_i == `CFG_ADDR |=> !cfg_ff[`BIT_BUSY])
		else $error("busy bit stored from write");
	a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
		start_det |=> busy_ff)
		else $error("busy not set after start");
	a_busy_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		en && stop_det && !start_det |=> !busy_ff)
		else $error("busy not cleared on stop");
	a_free_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		free_hit |=> stop_event_o && irq_req_o && !busy_ff)
		else $error("free timeout not acting as stop");
	a_inhibit_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		inh_ff && !master_event_i && !stop_det && !free_hit |=> !irq_req_o)
		else $error("slave interrupt while inhibited");
	a_slave_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		en && !inh_ff && slave_event_i |=> irq_req_o)
		else $error("slave event not reported");
	a_hold_time: assert property (@(posedge clk_i) disable iff (rst_i)
		hold_clks_o == (cfg_ff[`BIT_EXTEND] ? 4'hC : 4'h3))
		else $error("hold time wrong");
	a_scl_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		en && cfg_ff[`BIT_SCL_TOE] && !scl_s |-> !timeout_reload_o)
		else $error("timer held in reload while scl low");
	a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!en |=> !busy_ff && !stop_event_o && !irq_req_o)
		else $error("activity while disabled");
	a_disabled_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		!en |-> !bit_tick_o && !slave_active_o && timeout_reload_o)
		else $error("outputs active while disabled");
	a_setup_time: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_clks_o == (cfg_ff[`BIT_EXTEND] ? 4'hB : 4'h1))
		else $error("setup time wrong");
	// while enabled, busy moves only on a start, a stop or a free timeout
	a_busy_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		en && busy_ff && !stop_det && !free_hit |=> busy_ff)
		else $error("busy dropped without stop");
	a_idle_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		en && !busy_ff && !start_det |=> !busy_ff)
		else $error("busy set without start");
	a_stop_event: assert property (@(posedge clk_i) disable iff (rst_i)
		en && stop_det |=> stop_event_o && irq_req_o)
		else $error("stop not reported");
	a_master_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		en && master_event_i |=> irq_req_o)
		else $error("master interrupt lost");
	a_free_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		free_cnt_ff <= `FREE_PERIODS + 4'h1)
		else $error("free counter overran");
	a_free_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		!scl_s || !sda_s |=> free_cnt_ff == 4'h0)
		else $error("free count kept with a line low");
	a_reload_high: assert property (@(posedge clk_i) disable iff (rst_i)
		scl_s |-> timeout_reload_o)
		else $error("timer counting while scl high");
	a_tick_source: assert property (@(posedge clk_i) disable iff (rst_i)
		en |-> bit_tick_o == (cfg_ff[`CS_HI]
			? (cfg_ff[`CS_LO] ? t2l_ovf_i : t2h_ovf_i)
			: (cfg_ff[`CS_LO] ? t1_ovf_i : t0_ovf_i)))
		else $error("wrong overflow source");
endmodule
